// >>> fault_monitor_pkg.sv
// Package with constants and carriers for the driver fault monitor
`default_nettype none
package fault_monitor_pkg;
    // Register indices (plain port, word per index)
    localparam logic [3:0] ADDR_CTRL     = 4'h0;  // Control
    localparam logic [3:0] ADDR_STATUS   = 4'h1;  // Status flags
    localparam logic [3:0] ADDR_READBACK = 4'h2;  // Current readback
    // Control field positions
    localparam int CTRL_OFFTIME_LSB = 0;   // Off-time setting, 4 bits
    localparam int CTRL_DELAY_LSB   = 4;   // Short detect delay, 2 bits
    localparam int CTRL_GATE_LSB    = 6;   // Gate current, 4 bits
    localparam int CTRL_CURR_LSB    = 10;  // Current setting, 5 bits
    // Values after reset
    localparam logic [3:0] OFFTIME_RST = 4'h0;
    localparam logic [1:0] DELAY_RST   = 2'h0;
    localparam logic [3:0] GATE_RST    = 4'h0;
    localparam logic [4:0] CURR_RST    = 5'h00;
    // Short counter limit
    localparam logic [1:0] SHORT_LIMIT = 2'h3;
    // Detection delay times by setting (ns), 0 longest
    localparam int CLK_NS    = 40;
    localparam int DLY0_NS   = 3200;
    localparam int DLY1_NS   = 1600;
    localparam int DLY2_NS   = 800;
    localparam int DLY3_NS   = 400;
    localparam logic [7:0] DLY0_CYC = 8'((DLY0_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] DLY1_CYC = 8'((DLY1_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] DLY2_CYC = 8'((DLY2_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] DLY3_CYC = 8'((DLY3_NS + CLK_NS - 1) / CLK_NS);
    // Gate settings that get temperature compensation
    localparam logic [3:0] GATE_TC_A = 4'h5;
    localparam logic [3:0] GATE_TC_B = 4'hB;
    // Status flag carrier
    typedef struct packed {
        logic short_ground_flag;
        logic open_load_flag;
        logic temp_prewarn_flag;
        logic overtemp_shutdown_flag;
    } status_t;
endpackage : fault_monitor_pkg
`default_nettype wire

// >>> fault_monitor.sv
// Short, open load, temperature and undervoltage monitor of a driver
//
// Behaviour
// RULE1 - Short switches bridge off, ends chopper cycle
// RULE2 - Each short increments the short counter
// RULE3 - Polarity change decrements counter by one
// RULE4 - Counter at three latches shutdown until re-enable
// RULE5 - Persistent short sets flag, disable clears
// RULE6 - Output not high before delay means short
// RULE7 - Two-bit delay, zero longest, three shortest
// RULE8 - Host picks delay covering switching slope
// RULE9 - No chopper event during polarity sets open-load
// RULE10 - Open-load re-evaluated on each polarity toggle
// RULE11 - Open-load held while current below 1/16
// RULE12 - Prewarning at 100 C, shutdown at 150 C
// RULE13 - Overtemperature switches off, sets flag
// RULE14 - Compensated gate settings get one step more
// RULE15 - Undervoltage resets logic, switches all off
// RULE16 - Undervoltage clears current setting to zero
// RULE17 - Serial output zero while undervoltage
// RULE18 - Host treats zero readback as undervoltage
// RULE19 - Disable pin or zero off-time disable driver
// RULE20 - Counter floors at zero, clears on re-enable
`default_nettype none
module fault_monitor (
    input  wire logic        clk_in,                  // 25 MHz clock
    input  wire logic        rst_in,                  // Sync reset, high
    input  wire logic [3:0]  addr_in,                 // Register index
    input  wire logic [31:0] wdata_in,                // Write data
    input  wire logic        wr_in,                   // Write strobe
    input  wire logic        rd_in,                   // Read strobe
    input  wire logic        driver_disable_input,    // Pin, high disables
    input  wire logic        undervolt_in,            // Pin, supply low
    input  wire logic        bridge_output_sense,     // Pin, output high
    input  wire logic        high_on_in,              // High side on time
    input  wire logic        polarity_in,             // Phase polarity
    input  wire logic        chop_event_in,           // Chopper event
    input  wire logic        low_current_in,          // Current under 1/16
    input  wire logic        temp_warn_in,            // Pin, 100 C comparator
    input  wire logic        temp_shut_in,            // Pin, 150 C comparator
    input  wire logic        serial_data_in,          // Serial shift data
    output logic      [31:0] rdata_out,               // Read data
    output logic             bridge_off_out,          // Bridge switched off
    output logic             chop_end_out,            // End chopper cycle
    output logic             driver_enable_out,       // Driver running
    output logic      [3:0]  gate_current_out,        // Effective gate step
    output logic             serial_out               // Serial data out
);
    // Synchroniser stages for pin inputs
    logic [1:0] dis_sync_ff;    // Disable pin
    logic [1:0] uv_sync_ff;     // Undervoltage
    logic [1:0] sense_sync_ff;  // Bridge sense
    logic [1:0] warn_sync_ff;   // Temperature warning
    logic [1:0] shut_sync_ff;   // Temperature shutdown

    // Two flip-flops per pin
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            dis_sync_ff   <= 2'h3;
            uv_sync_ff    <= 2'h0;
            sense_sync_ff <= 2'h0;
            warn_sync_ff  <= 2'h0;
            shut_sync_ff  <= 2'h0;
        end else begin
            dis_sync_ff   <= {dis_sync_ff[0], driver_disable_input};
            uv_sync_ff    <= {uv_sync_ff[0], undervolt_in};
            sense_sync_ff <= {sense_sync_ff[0], bridge_output_sense};
            warn_sync_ff  <= {warn_sync_ff[0], temp_warn_in};
            shut_sync_ff  <= {shut_sync_ff[0], temp_shut_in};
        end
    end

    // Synchronised levels
    wire uv    = uv_sync_ff[1];
    wire sense = sense_sync_ff[1];
    wire warn  = warn_sync_ff[1];
    wire shut  = shut_sync_ff[1];

    // Control register fields
    logic [3:0] offtime_ff;     // Zero disables driver
    logic [1:0] delay_sel_ff;   // Short detect delay select
    logic [3:0] gate_ff;        // Gate current setting
    logic [4:0] curr_ff;        // Motor current setting

    // State
    logic [1:0] short_cnt_ff;   // Short event counter
    logic       latched_ff;     // Short shutdown latch
    logic       short_flag_ff;  // Short to ground flag
    logic       open_flag_ff;   // Open load flag
    logic       ot_flag_ff;     // Overtemperature flag
    logic       pol_ff;         // Previous polarity
    logic       chop_seen_ff;   // Chopper event in interval
    logic [7:0] dly_cnt_ff;     // High side on-time counter
    logic       tripped_ff;     // Bridge tripped this on time
    logic       was_dis_ff;     // Disabled last cycle

    // Decoding
    wire  sw_disable  = (offtime_ff == 4'h0);                 // RULE19
    wire  disabled    = dis_sync_ff[1] | sw_disable;          // RULE19
    wire  reenable    = was_dis_ff & ~disabled;
    wire  pol_change  = (polarity_in != pol_ff);
    wire  ctrl_wr     = wr_in & (addr_in == fault_monitor_pkg::ADDR_CTRL);
    logic [7:0] dly_lim;                                       // RULE7
    assign dly_lim = (delay_sel_ff == 2'h0) ? fault_monitor_pkg::DLY0_CYC :
                     (delay_sel_ff == 2'h1) ? fault_monitor_pkg::DLY1_CYC :
                     (delay_sel_ff == 2'h2) ? fault_monitor_pkg::DLY2_CYC :
                                              fault_monitor_pkg::DLY3_CYC;
    // Short detected: sense still low at delay end during on time
    wire  short_det   = high_on_in & ~tripped_ff & ~sense &
                        (dly_cnt_ff == dly_lim) & ~disabled;   // RULE6
    wire  cnt_up      = short_det & (short_cnt_ff != 2'h3);
    wire  cnt_dn      = pol_change & (short_cnt_ff != 2'h0);  // RULE20
    logic [1:0] nxt_short_cnt;
    assign nxt_short_cnt = (cnt_up && !cnt_dn) ? short_cnt_ff + 2'h1 :
                           (cnt_dn && !cnt_up) ? short_cnt_ff - 2'h1 :
                                                 short_cnt_ff;
    wire  hit_limit   = (nxt_short_cnt == fault_monitor_pkg::SHORT_LIMIT);
    wire  run         = ~disabled & ~latched_ff & ~ot_flag_ff & ~uv;
    wire  tc_gate     = (gate_ff == fault_monitor_pkg::GATE_TC_A) ||
                        (gate_ff == fault_monitor_pkg::GATE_TC_B);
    wire [3:0] gate_eff = (tc_gate && warn && gate_ff != 4'hF) ?
                          gate_ff + 4'h1 : gate_ff;           // RULE14
    fault_monitor_pkg::status_t status;
    assign status = '{short_ground_flag:      short_flag_ff,
                      open_load_flag:         open_flag_ff,
                      temp_prewarn_flag:      warn,
                      overtemp_shutdown_flag: ot_flag_ff};
    logic [31:0] rd_mux;
    assign rd_mux =
        (addr_in == fault_monitor_pkg::ADDR_CTRL) ?
            {17'h0, curr_ff, gate_ff, delay_sel_ff, offtime_ff} :
        (addr_in == fault_monitor_pkg::ADDR_STATUS) ?
            {28'h0, status} :
        (addr_in == fault_monitor_pkg::ADDR_READBACK) ?
            {27'h0, curr_ff} : 32'h0;

    // Control register, cleared by undervoltage
    always_ff @(posedge clk_in) begin
        if (rst_in || uv) begin                              // RULE15
            offtime_ff   <= fault_monitor_pkg::OFFTIME_RST;
            delay_sel_ff <= fault_monitor_pkg::DELAY_RST;
            gate_ff      <= fault_monitor_pkg::GATE_RST;
            curr_ff      <= fault_monitor_pkg::CURR_RST;      // RULE16
        end else if (ctrl_wr) begin
            offtime_ff   <= wdata_in[fault_monitor_pkg::CTRL_OFFTIME_LSB +: 4];
            delay_sel_ff <= wdata_in[fault_monitor_pkg::CTRL_DELAY_LSB +: 2];
            gate_ff      <= wdata_in[fault_monitor_pkg::CTRL_GATE_LSB +: 4];
            curr_ff      <= wdata_in[fault_monitor_pkg::CTRL_CURR_LSB +: 5];
        end
    end

    // On-time delay counter, one trip per on time
    always_ff @(posedge clk_in) begin
        if (rst_in || uv || !high_on_in) begin
            dly_cnt_ff <= 8'h00;
            tripped_ff <= 1'b0;
        end else begin
            if (dly_cnt_ff != dly_lim) begin
                dly_cnt_ff <= dly_cnt_ff + 8'h01;
            end
            if (short_det) begin
                tripped_ff <= 1'b1;
            end
        end
    end

    // Short counter, shutdown latch and flag
    always_ff @(posedge clk_in) begin
        if (rst_in || uv || disabled) begin
            short_cnt_ff  <= 2'h0;                            // RULE20
            latched_ff    <= 1'b0;                            // RULE4
            short_flag_ff <= 1'b0;                            // RULE5
        end else begin
            short_cnt_ff <= nxt_short_cnt;                    // RULE2 RULE3
            if (hit_limit) begin
                latched_ff    <= 1'b1;                        // RULE4
                short_flag_ff <= 1'b1;                        // RULE5
            end
        end
    end

    // Open load evaluation on polarity toggle
    always_ff @(posedge clk_in) begin
        if (rst_in || uv) begin
            open_flag_ff <= 1'b0;
            chop_seen_ff <= 1'b0;
            pol_ff       <= 1'b0;
        end else begin
            pol_ff <= polarity_in;
            if (pol_change) begin
                if (!low_current_in) begin                    // RULE11
                    open_flag_ff <= ~chop_seen_ff;            // RULE9 RULE10
                end
                chop_seen_ff <= chop_event_in;
            end else if (chop_event_in) begin
                chop_seen_ff <= 1'b1;
            end
        end
    end

    // Overtemperature latch, cleared by disabling
    always_ff @(posedge clk_in) begin
        if (rst_in || uv) begin
            ot_flag_ff <= 1'b0;
        end else if (shut) begin
            ot_flag_ff <= 1'b1;                               // RULE12 RULE13
        end else if (disabled) begin
            ot_flag_ff <= 1'b0;
        end
    end

    // Registered outputs; a tripped bridge stays off until on time ends
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rdata_out         <= 32'h0;
            bridge_off_out    <= 1'b1;
            chop_end_out      <= 1'b0;
            driver_enable_out <= 1'b0;
            gate_current_out  <= 4'h0;
            serial_out        <= 1'b0;
            was_dis_ff        <= 1'b1;
        end else begin
            rdata_out         <= rd_in ? rd_mux : 32'h0;
            bridge_off_out    <= short_det | tripped_ff | ~run; // RULE1 RULE15
            chop_end_out      <= short_det;                   // RULE1
            driver_enable_out <= run & ~shut;                 // RULE13
            gate_current_out  <= gate_eff;
            serial_out        <= uv ? 1'b0 : serial_data_in;  // RULE17
            was_dis_ff        <= disabled;
        end
    end

    // Assertions
    property p_short_off;  // RULE1
        @(posedge clk_in) disable iff (rst_in)
        short_det |=> bridge_off_out && chop_end_out;
    endproperty
    a_short_off: assert property (p_short_off)  // RULE1
        else $error("no trip");

    // Bridge kept off for the rest of a tripped on time
    property p_trip_hold;  // RULE1
        @(posedge clk_in) disable iff (rst_in)
        tripped_ff |=> bridge_off_out;
    endproperty
    a_trip_hold: assert property (p_trip_hold)  // RULE1
        else $error("bridge back on");

    // One step up per detected short
    property p_cnt_up;  // RULE2
        @(posedge clk_in) disable iff (rst_in)
        cnt_up && !cnt_dn && !uv |=>
            short_cnt_ff == 2'($past(short_cnt_ff) + 2'h1);
    endproperty
    a_cnt_up: assert property (p_cnt_up)  // RULE2
        else $error("count not raised");

    // One step down per polarity change
    property p_cnt_dn;  // RULE3
        @(posedge clk_in) disable iff (rst_in)
        cnt_dn && !cnt_up && !disabled && !uv |=>
            short_cnt_ff == 2'($past(short_cnt_ff) - 2'h1);
    endproperty
    a_cnt_dn: assert property (p_cnt_dn)  // RULE3
        else $error("count not lowered");

    property p_latch;  // RULE4
        @(posedge clk_in) disable iff (rst_in)
        latched_ff && !disabled && !uv |=> !driver_enable_out;
    endproperty
    a_latch: assert property (p_latch)  // RULE4
        else $error("latch ignored");

    // Reaching the limit latches shutdown and the flag
    property p_latch_set;  // RULE4
        @(posedge clk_in) disable iff (rst_in)
        hit_limit && !disabled && !uv |=> latched_ff && short_flag_ff;
    endproperty
    a_latch_set: assert property (p_latch_set)  // RULE4 RULE5
        else $error("limit not latched");

    property p_flag_clr;  // RULE5
        @(posedge clk_in) disable iff (rst_in)
        disabled |=> !short_flag_ff;
    endproperty
    a_flag_clr: assert property (p_flag_clr)  // RULE5
        else $error("flag kept");

    property p_ot;  // RULE13
        @(posedge clk_in) disable iff (rst_in)
        shut && !uv |=> ot_flag_ff && !driver_enable_out;
    endproperty
    a_ot: assert property (p_ot)  // RULE13
        else $error("no overtemp off");

    property p_uv_curr;  // RULE16
        @(posedge clk_in) disable iff (rst_in)
        uv |=> curr_ff == 5'h00;
    endproperty
    a_uv_curr: assert property (p_uv_curr)  // RULE16
        else $error("current kept");

    property p_uv_ser;  // RULE17
        @(posedge clk_in) disable iff (rst_in)
        uv |=> !serial_out && bridge_off_out;
    endproperty
    a_uv_ser: assert property (p_uv_ser)  // RULE17
        else $error("serial active");

    property p_floor;  // RULE20
        @(posedge clk_in) disable iff (rst_in)
        short_cnt_ff == 2'h0 && !short_det |=> short_cnt_ff == 2'h0;
    endproperty
    a_floor: assert property (p_floor)  // RULE20
        else $error("count wrapped");

    property p_disable;  // RULE19
        @(posedge clk_in) disable iff (rst_in)
        sw_disable |=> !driver_enable_out;
    endproperty
    a_disable: assert property (p_disable)  // RULE19
        else $error("runs disabled");

    property p_ol_hold;  // RULE11
        @(posedge clk_in) disable iff (rst_in)
        low_current_in && !uv |=> $stable(open_flag_ff);
    endproperty
    a_ol_hold: assert property (p_ol_hold)  // RULE11
        else $error("open load moved");

    // Toggle with enough current takes the chopper history
    property p_ol_eval;  // RULE9
        @(posedge clk_in) disable iff (rst_in)
        pol_change && !low_current_in && !uv |=>
            open_flag_ff == !$past(chop_seen_ff);
    endproperty
    a_ol_eval: assert property (p_ol_eval)  // RULE9 RULE10
        else $error("open load not evaluated");

    // Compensated settings one step up while warm
    property p_gate_tc;  // RULE14
        @(posedge clk_in) disable iff (rst_in)
        tc_gate && warn |=> gate_current_out == 4'($past(gate_ff) + 4'h1);
    endproperty
    a_gate_tc: assert property (p_gate_tc)  // RULE14
        else $error("gate not raised");

    c_trip:  cover property (@(posedge clk_in) short_det);
    c_latch: cover property (@(posedge clk_in) $rose(latched_ff));
    c_ol:    cover property (@(posedge clk_in) $rose(open_flag_ff));
    c_re:    cover property (@(posedge clk_in) reenable);
    c_tc:    cover property (@(posedge clk_in) tc_gate && warn);
endmodule : fault_monitor
`default_nettype wire

// >>> host_model.sv
// Host model: register port master and driver disable pin
`default_nettype none
module host_model (
    input  wire logic        clk_in,      // Bench clock
    input  wire logic [31:0] rdata_in,    // Read data from device
    output var  logic [3:0]  addr_out,    // Register index
    output var  logic [31:0] wdata_out,   // Write data
    output var  logic        wr_out,      // Write strobe
    output var  logic        rd_out,      // Read strobe
    output var  logic        disable_out  // Disable pin, high stops
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle bus at time zero
    initial begin
        addr_out    = 4'h0;
        wdata_out   = 32'h0;
        wr_out      = 1'b0;
        rd_out      = 1'b0;
        disable_out = 1'b0;
    end
    // One-cycle write of the given word to the given index
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk_in);
        addr_out  <= a;
        wdata_out <= v;
        wr_out    <= 1'b1;
        @(posedge clk_in);
        wr_out    <= 1'b0;
    endtask : wr_reg
    // One-cycle read, data taken in the following cycle
    task automatic rd_reg(input logic [3:0] a, output logic [31:0] v);
        @(posedge clk_in);
        addr_out <= a;
        rd_out   <= 1'b1;
        @(posedge clk_in);
        rd_out   <= 1'b0;
        #1 v = rdata_in;
    endtask : rd_reg
    // Hardware disable pin, then settle through the synchroniser
    task automatic set_disable(input logic v);
        @(posedge clk_in);
        disable_out <= v;
        repeat (5) @(posedge clk_in);
        #1;
    endtask : set_disable
endmodule : host_model
`default_nettype wire

// >>> tb_top.sv
// Self-checking bench for the driver fault monitor
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_in         = 1'b0;  // 25 MHz clock
    logic        rst_in         = 1'b1;  // Sync reset
    logic [3:0]  addr_in;                // Host bus
    logic [31:0] wdata_in;
    logic        wr_in;
    logic        rd_in;
    logic        dis_pin;                // Disable pin
    logic        undervolt_in   = 1'b0;
    logic        sense_in       = 1'b0;  // Output level reached
    logic        high_on_in     = 1'b0;
    logic        polarity_in    = 1'b0;
    logic        chop_event_in  = 1'b0;
    logic        low_current_in = 1'b0;
    logic        temp_warn_in   = 1'b0;
    logic        temp_shut_in   = 1'b0;
    logic        ser_in         = 1'b0;
    logic [31:0] rdata_out;
    logic        bridge_off_out;
    logic        chop_end_out;
    logic        driver_enable_out;
    logic [3:0]  gate_current_out;
    logic        serial_out;
    int          err_total      = 0;     // Mismatches
    int          tests_run      = 0;     // Comparisons
    int          cyc            = 0;     // Timeout count
    int          cnt_m          = 0;     // Model short counter
    logic        ol_m           = 1'b0;  // Model open-load flag
    logic [4:0]  cur;                    // Random current setting
    logic        ser_prev;               // Serial bit of the last edge
    int          lim[4]         = '{80, 40, 20, 10};
    fault_monitor u_fault_monitor (.clk_in, .rst_in, .addr_in, .wdata_in,
        .wr_in, .rd_in, .driver_disable_input(dis_pin), .undervolt_in,
        .bridge_output_sense(sense_in), .high_on_in, .polarity_in,
        .chop_event_in, .low_current_in, .temp_warn_in, .temp_shut_in,
        .serial_data_in(ser_in), .rdata_out, .bridge_off_out,
        .chop_end_out, .driver_enable_out, .gate_current_out, .serial_out);
    host_model u_host_model (.clk_in, .rdata_in(rdata_out),
        .addr_out(addr_in), .wdata_out(wdata_in), .wr_out(wr_in),
        .rd_out(rd_in), .disable_out(dis_pin));
    // Clock and hang guard
    always #20 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            report_and_stop();
        end
    end
    // Compare and count
    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s expected %0h seen %0h", n, e, g);
        end
    endtask : chk
    // Register read compare
    task automatic rchk(input string n, input logic [3:0] a,
                        input logic [31:0] e);
        logic [31:0] v;
        u_host_model.rd_reg(a, v);
        chk(n, e, v);
    endtask : rchk
    // Wait edges, then step off the edge
    task automatic wt(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : wt
    // Temperature comparator pins, changed at a clock edge
    task automatic set_temp(input logic w, input logic s);
        @(posedge clk_in);
        temp_warn_in <= w;
        temp_shut_in <= s;
    endtask : set_temp
    // Control word: current, gate, delay, nonzero off-time
    task automatic cfg(input logic [1:0] dl, input logic [3:0] g);
        u_host_model.wr_reg(fault_monitor_pkg::ADDR_CTRL,
                            {17'h0, cur, g, dl, 4'h4});
        wt(4);
    endtask : cfg
    // One high-side on time with the output held low
    task automatic trip(input int lo);
        int n;
        n = 0;
        @(posedge clk_in);
        high_on_in <= 1'b1;
        do begin
            @(posedge clk_in);
            #1 n++;
        end while (bridge_off_out !== 1'b1 && n < 200);
        chk("trip delay", 1, 32'(n >= lo && n <= lo + 6));
        chk("chop end", 1, 32'(chop_end_out));
        @(posedge clk_in);
        high_on_in <= 1'b0;
        if (cnt_m < 3) cnt_m++;
        wt(4);
    endtask : trip
    // Polarity period with optional chopper event
    task automatic pol(input logic ev, input logic lowc);
        @(posedge clk_in);
        chop_event_in  <= ev;
        low_current_in <= lowc;
        @(posedge clk_in);
        chop_event_in  <= 1'b0;
        repeat (2) @(posedge clk_in);
        polarity_in    <= ~polarity_in;
        if (!lowc) ol_m = !ev;
        if (cnt_m > 0) cnt_m--;
        repeat (3) @(posedge clk_in);
        low_current_in <= 1'b0;
        wt(2);
    endtask : pol
    // Closing report
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : report_and_stop
    // Main sequence
    initial begin
        void'($urandom(66));
        cur = 5'($urandom_range(31, 1));
        repeat (4) @(posedge clk_in);
        rst_in <= 1'b0;
        wt(3);
        chk("bridge off", 1, 32'(bridge_off_out));
        rchk("status", fault_monitor_pkg::ADDR_STATUS, 32'h0);
        rchk("unmapped", 4'hF, 32'h0);
        cfg(2'h3, 4'h5);
        rchk("readback", fault_monitor_pkg::ADDR_READBACK, 32'(cur));
        chk("enable", 1, 32'(driver_enable_out));
        u_host_model.set_disable(1'b1);
        chk("enable", 0, 32'(driver_enable_out));
        u_host_model.set_disable(1'b0);
        $display("test reset_regs done");
        pol(1'b0, 1'b0);
        rchk("status", 4'h1, {29'h0, ol_m, 2'h0});
        pol(1'b1, 1'b1);
        rchk("status", 4'h1, {29'h0, ol_m, 2'h0});
        pol(1'b1, 1'b0);
        rchk("status", 4'h1, {29'h0, ol_m, 2'h0});
        $display("test open_load done");
        @(posedge clk_in);
        sense_in   <= 1'b1;
        high_on_in <= 1'b1;
        wt(100);
        chk("no trip", 0, 32'(bridge_off_out));
        high_on_in <= 1'b0;
        sense_in   <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            cfg(2'(i), 4'h5);
            trip(lim[i]);
            pol(1'b1, 1'b0);
            chk("enable", 1, 32'(driver_enable_out));
        end
        trip(10);
        trip(10);
        pol(1'b1, 1'b0);
        trip(10);
        chk("enable", 1, 32'(driver_enable_out));
        trip(10);
        chk("enable", 0, 32'(driver_enable_out));
        chk("bridge off", 1, 32'(bridge_off_out));
        rchk("status", 4'h1, {28'h0, cnt_m == 3, ol_m, 2'h0});
        u_host_model.set_disable(1'b1);
        rchk("status", 4'h1, {29'h0, ol_m, 2'h0});
        u_host_model.set_disable(1'b0);
        cnt_m = 0;
        chk("enable", 1, 32'(driver_enable_out));
        trip(10);
        trip(10);
        chk("enable", 1, 32'(driver_enable_out));
        pol(1'b1, 1'b0);
        pol(1'b1, 1'b0);
        $display("test short_ground done");
        set_temp(1'b1, 1'b0);
        wt(5);
        chk("gate", 32'h6, 32'(gate_current_out));
        rchk("status", 4'h1, {29'h0, ol_m, 2'h2});
        cfg(2'h3, 4'hB);
        chk("gate", 32'hC, 32'(gate_current_out));
        cfg(2'h3, 4'h3);
        chk("gate", 32'h3, 32'(gate_current_out));
        set_temp(1'b1, 1'b1);
        wt(5);
        chk("enable", 0, 32'(driver_enable_out));
        rchk("status", 4'h1, {29'h0, ol_m, 2'h3});
        set_temp(1'b0, 1'b0);
        cfg(2'h3, 4'hB);
        chk("gate", 32'hB, 32'(gate_current_out));
        u_host_model.set_disable(1'b1);
        u_host_model.set_disable(1'b0);
        rchk("status", 4'h1, {29'h0, ol_m, 2'h0});
        chk("enable", 1, 32'(driver_enable_out));
        $display("test temperature done");
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_in);
            ser_prev = ser_in;
            ser_in <= 1'($urandom);
            #1 chk("serial", 32'(ser_prev), 32'(serial_out));
        end
        undervolt_in <= 1'b1;
        wt(4);
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_in);
            ser_in <= 1'($urandom);
            #1 chk("serial", 0, 32'(serial_out));
        end
        chk("enable", 0, 32'(driver_enable_out));
        chk("bridge off", 1, 32'(bridge_off_out));
        undervolt_in <= 1'b0;
        wt(4);
        rchk("readback", 4'h2, 32'h0);
        rchk("status", 4'h1, 32'h0);
        chk("enable", 0, 32'(driver_enable_out));
        $display("test undervoltage done");
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
